// ---- dv/pin_host.sv ----
// host and board model resolving each pin level
`timescale 1ns/100ps
`include "pin_port_consts.svh"
module pin_host
(
    input wire logic sys_clk,
    input wire pin_port_pkg::pin_drive_type [`PIN_COUNT-1:0] drive,
    input wire logic [`PIN_COUNT-1:0] host_en,
    input wire logic [`PIN_COUNT-1:0] host_val,
    output logic [`PIN_COUNT-1:0] level
);
    import pin_port_pkg::*;
    logic flip = 1'b0;
    // a floating pin never settles, so nothing may rely on it
    always @(posedge sys_clk)
        flip <= ~flip;
    always_comb
    begin
        for (int i = 0; i < `PIN_COUNT; i++)
        begin
            if (drive[i].oe)
                level[i] = drive[i].out;
            else if (host_en[i])
                level[i] = host_val[i];
            else if (drive[i].pull_up || drive[i].pull_down)
                level[i] = drive[i].pull_up;
            else
                level[i] = flip ^ i[0];
        end
    end
endmodule

// ---- dv/pin_port_chk.sv ----
// assertion checker for the pin port
`timescale 1ns/100ps
`include "pin_port_consts.svh"
module pin_port_chk
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pin_port_pkg::reg_req_type reg_req,
    input wire logic [31:0] reg_rdata,
    input wire logic [`PIN_COUNT-1:0] general_pin_in,
    input wire pin_port_pkg::pin_drive_type [`PIN_COUNT-1:0] general_pin_drive,
    input wire logic wake_request
);
    import pin_port_pkg::*;
    // ------
    // shadow of pin 0 settings and of the shared step and duty
    // ------
    logic [9:0] cfg0;
    logic [31:0] step;
    logic [15:0] duty;
    logic [9:0] quiet;
    wire w0 = reg_req.wr && reg_req.addr == `CFG_BASE;
    wire hi_wake = cfg0[7] && cfg0[9:8] == 2'b01 && cfg0[4:3] != 2'b11;
    wire chg_wake = cfg0[7] && cfg0[9:8] == 2'b10 && cfg0[4:3] != 2'b11;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg0 <= `CFG_RESET;
            step <= `SQ_STEP_RESET;
            duty <= `PWM_DUTY_RESET;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == `CFG_BASE)
                cfg0 <= reg_req.wdata[9:0];
            if (reg_req.addr == `SQ_STEP_ADDR)
                step <= reg_req.wdata;
            if (reg_req.addr == `PWM_DUTY_ADDR)
                duty <= reg_req.wdata[15:0];
        end
    end
    // settings reach the outputs through a few register stages, so outputs are judged late
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            quiet <= '0;
        else if (reg_req.wr)
            quiet <= '0;
        else if (quiet != 10'h3FF)
            quiet <= quiet + 10'h001;
    end
    // ------
    // properties
    // ------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_rdata_idle;
        !$past(reg_req.rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside its cycle");
    property p_unmapped;
        reg_req.rd && (reg_req.addr inside {[8'h4C:8'h7C], [8'h94:8'hBC]})
        |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_gpio_out;
        w0 && reg_req.wdata[6:5] == 2'b00 && reg_req.wdata[0] ##1 !w0
        |=> general_pin_drive[0].oe
            && general_pin_drive[0].out == $past(reg_req.wdata[1], 2)
            && general_pin_drive[0].high_drive == $past(reg_req.wdata[2], 2);
    endproperty
    a_gpio_out: assert property (p_gpio_out)
        else $error("pin drive does not follow its setting");
    property p_pull;
        w0 && !reg_req.wdata[0] ##1 !w0
        |=> general_pin_drive[0].pull_up == ($past(reg_req.wdata[4:3], 2) == 2)
            && general_pin_drive[0].pull_down
            == ($past(reg_req.wdata[4:3], 2) == 1);
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull selection wrong");
    property p_wake_hi;
        hi_wake && general_pin_in[0] ##1 hi_wake |=> wake_request;
    endproperty
    a_wake_hi: assert property (p_wake_hi)
        else $error("high level did not wake");
    property p_wake_chg;
        chg_wake && $changed(general_pin_in[0]) ##1 chg_wake |=> wake_request;
    endproperty
    a_wake_chg: assert property (p_wake_chg)
        else $error("pin change did not wake");
    property p_sq_hold;
        quiet >= 10'd8 && step == 32'h0 && cfg0[6:5] == 2'b10 && cfg0[0]
        |-> $stable(general_pin_drive[0].out);
    endproperty
    a_sq_hold: assert property (p_sq_hold)
        else $error("square output moves at zero frequency");
    property p_pwm_off;
        quiet == 10'h3FF && duty == 16'h0 && cfg0[6:5] == 2'b01 && cfg0[0]
        |-> !general_pin_drive[0].out;
    endproperty
    a_pwm_off: assert property (p_pwm_off)
        else $error("pulse output high at zero duty");
    c_wake: cover property ($rose(wake_request));
    c_sq: cover property (step != 32'h0 && cfg0[6:5] == 2'b10);
    c_read: cover property (reg_req.rd && reg_req.addr == `IN_ADDR);
endmodule

bind pin_port pin_port_chk chk
(
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .general_pin_in(general_pin_in),
    .general_pin_drive(general_pin_drive), .wake_request(wake_request)
);

// ---- dv/testbench.sv ----
// self-checking bench for the pin port
`timescale 1ns/100ps
`include "pin_port_consts.svh"
module testbench;
    import pin_port_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    reg_req_type reg_req = '0;
    logic [31:0] reg_rdata;
    logic [`PIN_COUNT-1:0] pin_in;
    pin_drive_type [`PIN_COUNT-1:0] drive;
    logic wake_request;
    logic [`PIN_COUNT-1:0] host_en = '0;
    logic [`PIN_COUNT-1:0] host_val = '0;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int h0;
    int h1;
    int h2;
    int tg;
    int tp[5] = '{4, 4, 4, 10, 2};
    int td[5] = '{1, 0, 4, 3, 1};
    int th[5] = '{500, 0, 2000, 600, 1000};
    always #5 sys_clk = ~sys_clk;
    pin_port uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .general_pin_in(pin_in),
        .general_pin_drive(drive), .wake_request(wake_request)
    );
    pin_host host
    (
        .sys_clk(sys_clk), .drive(drive), .host_en(host_en),
        .host_val(host_val), .level(pin_in)
    );
    // ------
    // tasks
    // ------
    task automatic report_and_stop();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1;
        check32(reg_rdata, exp);
    endtask
    task automatic set_all(input logic [31:0] c);
        for (int i = 0; i < `PIN_COUNT; i++)
            wr_reg(`CFG_BASE + 8'(4 * i), c);
        tick(3);
    endtask
    task automatic pin0(input logic v);
        @(posedge sys_clk);
        host_en[0] <= 1'b1;
        host_val[0] <= v;
        tick(4);
    endtask
    task automatic clr();
        wr_reg(`WAKE_STAT_ADDR, 32'h7FFFF);
        tick(3);
    endtask
    task automatic measure(input int n);
        logic prev;
        h0 = 0;
        h1 = 0;
        h2 = 0;
        tg = 0;
        prev = drive[0].out;
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            h0 += int'(drive[0].out);
            h1 += int'(drive[1].out);
            h2 += int'(drive[16].out);
            tg += int'(drive[0].out != prev);
            prev = drive[0].out;
        end
    endtask
    // ------
    // tests
    // ------
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            $display("ERROR %0t: timeout", $time);
            report_and_stop();
        end
    end
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < `PIN_COUNT; i++)
            rd_chk(`CFG_BASE + 8'(4 * i), 32'h0);
        rd_chk(`PWM_PERIOD_ADDR, 32'(`PWM_PERIOD_RESET));
        rd_chk(`SQ_STEP_ADDR, 32'h0);
        for (int j = 0; j < `SQ_PIN_COUNT; j++)
            rd_chk(`SQ_DUTY_BASE + 8'(4 * j), 32'(`SQ_DUTY_RESET));
        rd_chk(8'h50, 32'h0);
        $display("reset test done");
        for (int i = 0; i < `PIN_COUNT; i++)
        begin
            wr_reg(`CFG_BASE + 8'(4 * i), {29'h0, 1'(i), 2'b11});
            tick(1);
            check32(32'(drive[i]), 32'({3'b111 & {2'b11, 1'(i)}, 2'b00}));
        end
        rd_chk(`IN_ADDR, 32'h7FFFF);
        set_all(32'h10);
        rd_chk(`IN_ADDR, 32'h7FFFF);
        check32({drive[7].oe, drive[7].pull_up, drive[7].pull_down}, 3'b010);
        set_all(32'h08);
        rd_chk(`IN_ADDR, 32'h0);
        set_all(32'h18);
        @(posedge sys_clk);
        host_en <= '1;
        host_val <= '1;
        tick(3);
        rd_chk(`IN_ADDR, 32'h0);
        @(posedge sys_clk);
        host_en <= '0;
        set_all(32'h08);
        $display("pin setting test done");
        wr_reg(`CFG_BASE, 32'h188);
        tick(3);
        clr();
        check32(32'(wake_request), 32'h0);
        pin0(1'b1);
        check32(32'(wake_request), 32'h1);
        rd_chk(`WAKE_STAT_ADDR, 32'h1);
        pin0(1'b0);
        clr();
        check32(32'(wake_request), 32'h0);
        wr_reg(`CFG_BASE, 32'h090);
        tick(4);
        check32(32'(wake_request), 32'h1);
        pin0(1'b1);
        wr_reg(`CFG_BASE, 32'h290);
        tick(3);
        clr();
        check32(32'(wake_request), 32'h0);
        pin0(1'b0);
        check32(32'(wake_request), 32'h1);
        clr();
        check32(32'(wake_request), 32'h0);
        pin0(1'b1);
        check32(32'(wake_request), 32'h1);
        @(posedge sys_clk);
        host_en <= '0;
        wr_reg(`CFG_BASE, 32'h08);
        clr();
        wr_reg(`CFG_BASE, 32'h390);
        tick(5);
        check32(32'(wake_request), 32'h0);
        $display("wake test done");
        wr_reg(`CFG_BASE, 32'h21);
        wr_reg(`CFG_BASE + 8'h04, 32'h21);
        for (int k = 0; k < 5; k++)
        begin
            wr_reg(`PWM_PERIOD_ADDR, 32'(tp[k]));
            wr_reg(`PWM_DUTY_ADDR, 32'(td[k]));
            tick(1100);
            measure(2000);
            check32(32'(h0), 32'(th[k]));
            check32(32'(h1), 32'(th[k]));
        end
        $display("pulse-width test done");
        wr_reg(`CFG_BASE, 32'h41);
        wr_reg(`CFG_BASE + 8'h04, 32'h41);
        wr_reg(`CFG_BASE + 8'h40, 32'h41);
        wr_reg(`SQ_DUTY_BASE + 8'h04, 32'h40);
        rd_chk(`SQ_DUTY_BASE + 8'h04, 32'h40);
        wr_reg(`SQ_STEP_ADDR, 32'h0100_0000);
        tick(20);
        measure(512);
        check32(32'(h0), 32'd256);
        check32(32'(h1), 32'd128);
        check32(32'(h2), 32'd0);
        wr_reg(`SQ_STEP_ADDR, 32'h8000_0000);
        tick(20);
        measure(1000);
        check32(32'(tg >= 78 && tg <= 82), 32'h1);
        wr_reg(`SQ_STEP_ADDR, 32'h0);
        tick(20);
        measure(300);
        check32(32'(tg), 32'h0);
        $display("square-wave test done");
        report_and_stop();
    end
endmodule

// ---- rtl/pin_port.sv ----
// general pin port with pulse-width, square-wave and wake logic
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "pin_port_consts.svh"

// What this block does
// R1: nineteen pins, each configured separately, input/output
// R2: per-pin standard or high drive strength
// R3: pull-up, pull-down, none, or input disconnect
// R4: wake on configured high or low level
// R5: optional wake on any input change
// R6: host drives wake pin to match trigger
// R7: pulse-width output from hardware on any pin
// R8: pulse-width up to 1 MHz, 0-100% duty
// R9: duty steps equal period in microsecond ticks
// R10: square wave on sixteen pins, one frequency
// R11: separate square-wave duty per pin
// R12: square wave 0 Hz to 4 MHz, default 50%
// R13: function selector picks one output source
// R14: zero square-wave frequency holds steady level
module pin_port
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire pin_port_pkg::reg_req_type reg_req,
    output logic [31:0] reg_rdata,
    input wire logic [`PIN_COUNT-1:0] general_pin_in,
    output pin_port_pkg::pin_drive_type [`PIN_COUNT-1:0] general_pin_drive,
    output logic wake_request
);
    import pin_port_pkg::*;

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [`CFG_WIDTH-1:0] cfg [`PIN_COUNT];
    logic [15:0] pwm_period;
    logic [15:0] pwm_duty;
    logic [31:0] sq_step;
    logic [`SQ_PIN_COUNT*8-1:0] sq_duty;
    logic [`PIN_COUNT-1:0] wake_stat;
    logic [`PIN_COUNT-1:0] pin_value;
    logic [`PIN_COUNT-1:0] pin_prev;
    logic [`PIN_COUNT-1:0] wake_hit;
    logic [`PIN_COUNT-1:0] stat_clear;
    logic pwm_wave;
    logic [`SQ_PIN_COUNT-1:0] sq_wave;
    logic [31:0] next_rdata;
    logic [31:0] step_in;
    logic next_wake_request;

    // ------------------------------------------------------------
    // per-pin configuration and pin logic
    // ------------------------------------------------------------
    // a one written to a status bit clears it, a zero leaves it alone
    assign stat_clear = (reg_req.wr && reg_req.addr == `WAKE_STAT_ADDR)
        ? reg_req.wdata[`PIN_COUNT-1:0] : '0;

    genvar i;
    generate
        for (i = 0; i < `PIN_COUNT; i++)
        begin : g_pin
            localparam logic [7:0] CFG_ADDR = 8'(`CFG_BASE + 4 * i);
            pull_type pull;
            func_type func;
            wake_type wmode;
            logic src;

            assign pull = pull_type'(cfg[i][`CFG_PULL_LSB +: 2]);
            assign func = func_type'(cfg[i][`CFG_FUNC_LSB +: 2]);
            assign wmode = wake_type'(cfg[i][`CFG_WAKE_MODE_LSB +: 2]);

            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    cfg[i] <= `CFG_RESET;
                else if (reg_req.wr && reg_req.addr == CFG_ADDR)
                    cfg[i] <= reg_req.wdata[`CFG_WIDTH-1:0]; // R1
            end

            // --------------------------------------------------------
            // output selection and pad controls
            // --------------------------------------------------------
            // pins above the square-wave range cannot carry it
            always_comb
            begin
                case (func)
                    func_pwm_v:
                        src = pwm_wave; // R7 R13
                    func_square_v:
                    begin
                        if (i < `SQ_PIN_COUNT)
                            src = sq_wave[i % `SQ_PIN_COUNT]; // R10 R13
                        else
                            src = cfg[i][`CFG_OUT_BIT];
                    end
                    default:
                        src = cfg[i][`CFG_OUT_BIT]; // R13
                endcase
            end

            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    general_pin_drive[i] <= '0;
                else
                begin
                    general_pin_drive[i].oe <= cfg[i][`CFG_DIR_BIT]; // R1
                    general_pin_drive[i].out <= src;
                    general_pin_drive[i].high_drive <=
                        cfg[i][`CFG_DRIVE_BIT]; // R2
                    general_pin_drive[i].pull_up <=
                        (pull == pull_up_type_v); // R3
                    general_pin_drive[i].pull_down <=
                        (pull == pull_down_type_v); // R3
                end
            end

            // --------------------------------------------------------
            // input sampling and wake detection
            // --------------------------------------------------------
            // a disconnected input buffer reads as zero
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    pin_value[i] <= 1'b0;
                else if (pull == pull_disconnect_type_v)
                    pin_value[i] <= 1'b0; // R3
                else
                    pin_value[i] <= general_pin_in[i];
            end

            // same reset level as pin_value, so no false change after reset
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    pin_prev[i] <= 1'b0;
                else
                    pin_prev[i] <= pin_value[i];
            end

            always_comb
            begin
                wake_hit[i] = 1'b0;
                if (cfg[i][`CFG_WAKE_EN_BIT])
                begin
                    case (wmode)
                        wake_low_v:
                            wake_hit[i] = !pin_value[i]; // R4 R6
                        wake_high_v:
                            wake_hit[i] = pin_value[i]; // R4 R6
                        wake_change_v:
                            wake_hit[i] = pin_value[i] ^ pin_prev[i]; // R5
                        default:
                            wake_hit[i] = 1'b0;
                    endcase
                end
            end

            // a hit in the clearing cycle keeps the flag set
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    wake_stat[i] <= 1'b0;
                else if (wake_hit[i])
                    wake_stat[i] <= 1'b1; // R4 R5
                else if (stat_clear[i])
                    wake_stat[i] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // wake request
    // ------------------------------------------------------------
    // the live hit is ored in so that a hit landing in a clearing
    // cycle still raises the request without waiting a cycle
    assign next_wake_request = |(wake_stat | wake_hit);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            wake_request <= 1'b0;
        else
            wake_request <= next_wake_request; // R4 R5
    end

    // ------------------------------------------------------------
    // pulse-width and square-wave settings
    // ------------------------------------------------------------
    // new settings reach the generators in the cycle after the write, without waiting for a period end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_period <= `PWM_PERIOD_RESET;
            pwm_duty <= `PWM_DUTY_RESET;
        end
        else if (reg_req.wr)
        begin
            if (reg_req.addr == `PWM_PERIOD_ADDR)
                pwm_period <= reg_req.wdata[15:0]; // R8
            if (reg_req.addr == `PWM_DUTY_ADDR)
                pwm_duty <= reg_req.wdata[15:0]; // R8
        end
    end

    // steps above the 4 MHz ceiling are clamped rather than aliased
    always_comb
    begin
        if (reg_req.wdata > `SQ_MAX_STEP)
            step_in = `SQ_MAX_STEP; // R12
        else
            step_in = reg_req.wdata;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sq_step <= `SQ_STEP_RESET;
        else if (reg_req.wr && reg_req.addr == `SQ_STEP_ADDR)
            sq_step <= step_in; // R12
    end

    genvar k;
    generate
        for (k = 0; k < `SQ_PIN_COUNT; k++)
        begin : g_sq_duty
            // only the first sixteen pins own a duty setting
            localparam logic [7:0] DUTY_ADDR = 8'(`SQ_DUTY_BASE + 4 * k);
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    sq_duty[k*8 +: 8] <= `SQ_DUTY_RESET; // R12
                else if (reg_req.wr && reg_req.addr == DUTY_ADDR)
                    sq_duty[k*8 +: 8] <= reg_req.wdata[7:0]; // R11
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // generators
    // ------------------------------------------------------------
    // one pulse-width generator is shared by every pin that selects it
    pwm_gen u_pwm
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .period(pwm_period),
        .duty(pwm_duty),
        .pwm_out(pwm_wave)
    );

    sq_gen u_sq
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .step(sq_step),
        .duty(sq_duty),
        .wave(sq_wave)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped addresses read as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        for (int n = 0; n < `PIN_COUNT; n++)
        begin
            if (reg_req.addr == 8'(`CFG_BASE + 4 * n))
                next_rdata = {22'h000000, cfg[n]};
        end
        for (int m = 0; m < `SQ_PIN_COUNT; m++)
        begin
            if (reg_req.addr == 8'(`SQ_DUTY_BASE + 4 * m))
                next_rdata = {24'h000000, sq_duty[m*8 +: 8]};
        end
        case (reg_req.addr)
            `IN_ADDR:
                next_rdata = {13'h0000, pin_value}; // R1
            `WAKE_STAT_ADDR:
                next_rdata = {13'h0000, wake_stat};
            `PWM_PERIOD_ADDR:
                next_rdata = {16'h0000, pwm_period};
            `PWM_DUTY_ADDR:
                next_rdata = {16'h0000, pwm_duty};
            `SQ_STEP_ADDR:
                next_rdata = sq_step;
            default:
                next_rdata = next_rdata;
        endcase
    end

    // data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0000_0000;
        else if (reg_req.rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule

// ---- rtl/pin_port_consts.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef PIN_PORT_CONSTS_SVH
`define PIN_PORT_CONSTS_SVH

`define PIN_COUNT 19
`define SQ_PIN_COUNT 16

`define CFG_BASE 8'h00
`define IN_ADDR 8'h80
`define WAKE_STAT_ADDR 8'h84
`define PWM_PERIOD_ADDR 8'h88
`define PWM_DUTY_ADDR 8'h8C
`define SQ_STEP_ADDR 8'h90
`define SQ_DUTY_BASE 8'hC0

`define CFG_DIR_BIT 0
`define CFG_OUT_BIT 1
`define CFG_DRIVE_BIT 2
`define CFG_PULL_LSB 3
`define CFG_FUNC_LSB 5
`define CFG_WAKE_EN_BIT 7
`define CFG_WAKE_MODE_LSB 8
`define CFG_WIDTH 10

`define CFG_RESET 10'h000
`define PWM_PERIOD_RESET 16'h03E8
`define PWM_DUTY_RESET 16'h0000
`define SQ_STEP_RESET 32'h0000_0000
`define SQ_DUTY_RESET 8'h80

`define CLK_PERIOD_NS 10
`define PWM_TICK_NS 1000
`define SQ_MAX_STEP 32'h0A3D_70A3

`endif

// ---- rtl/pin_port_pkg.sv ----
// shared types of the pin port
package pin_port_pkg;

    typedef enum logic [1:0] {
        pull_none_type_v,
        pull_down_type_v,
        pull_up_type_v,
        pull_disconnect_type_v
    } pull_type;

    typedef enum logic [1:0] {
        func_gpio_v,
        func_pwm_v,
        func_square_v,
        func_spare_v
    } func_type;

    typedef enum logic [1:0] {
        wake_low_v,
        wake_high_v,
        wake_change_v,
        wake_spare_v
    } wake_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic oe;
        logic out;
        logic high_drive;
        logic pull_up;
        logic pull_down;
    } pin_drive_type;

endpackage

// ---- rtl/pwm_gen.sv ----
// pulse-width generator counting microsecond ticks
`timescale 1ns/100ps
`include "pin_port_consts.svh"

module pwm_gen
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    output logic pwm_out
);
    localparam int TICK_CYCLES = `PWM_TICK_NS / `CLK_PERIOD_NS;

    logic [6:0] div;
    logic tick;
    logic [15:0] count;
    logic [15:0] last;

    // a period of zero is taken as one tick, i.e. the 1 MHz ceiling
    assign last = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
    assign tick = (div == 7'(TICK_CYCLES - 1));

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div <= 7'h00;
        else if (tick)
            div <= 7'h00;
        else
            div <= div + 7'h01;
    end

    // steps per period equal the period in ticks
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= 16'h0000;
        else if (tick)
            count <= (count >= last) ? 16'h0000 : count + 16'h0001; // R9
    end

    // duty at or above the period gives 100%, zero gives 0%
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pwm_out <= 1'b0;
        else
            pwm_out <= (count < duty); // R8
    end

endmodule

// ---- rtl/sq_gen.sv ----
// shared-frequency square wave with a duty compare per pin
`timescale 1ns/100ps
`include "pin_port_consts.svh"

module sq_gen
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [31:0] step,
    input wire logic [`SQ_PIN_COUNT*8-1:0] duty,
    output logic [`SQ_PIN_COUNT-1:0] wave
);
    logic [31:0] phase;

    // zero step freezes the phase so every output holds its level
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            phase <= 32'h0000_0000;
        else
            phase <= phase + step; // R12 R14
    end

    genvar j;
    generate
        for (j = 0; j < `SQ_PIN_COUNT; j++)
        begin : g_wave
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    wave[j] <= 1'b0;
                else
                    wave[j] <= (phase[31:24] < duty[j*8 +: 8]); // R11
            end
        end
    endgenerate

endmodule
